// ---- hw/ipd_config_words.sv ----
/*
  Serial receiver and decoder for the IF feedback-counter, IF
  reference-divider and factory test configuration words.
  Assumes the link pins and the default-select level arrive unsynchronised;
  the link clock is much slower than ref_clk_i (800 ns vs 100 ns).
*/
`timescale 1ns/1ps
`include "ipd_defines.svh"

module ipd_config_words #(
  parameter logic [3:0] DEF_SWALLOW = `IPD_DEF_SWALLOW,
  parameter logic [8:0] DEF_MAIN    = `IPD_DEF_MAIN,
  parameter logic [8:0] DEF_REF     = `IPD_DEF_REF
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  input  wire ipd_pkg::ipd_serial_t link_i,
  input  wire logic                 use_default_dividers_i,
  output ipd_pkg::ipd_div_cfg_t     div_cfg_o,
  output ipd_pkg::ipd_ratio_t       fb_ratio_o,
  output logic                      test_active_o,
  output logic                      word_taken_o,
  output logic                      fixed_bad_o
);
  import ipd_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  ipd_serial_t link_s1;
  ipd_serial_t link_s2;
  ipd_serial_t link_d;
  logic        def_s1;
  logic        def_s2;

  // Two flops per pin; only stage two is read by logic
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_s1 <= '0;
      link_s2 <= '0;
      def_s1  <= 1'b1;
      def_s2  <= 1'b1;
    end else begin
      link_s1 <= link_i;
      link_s2 <= link_s1;
      def_s1  <= use_default_dividers_i;
      def_s2  <= def_s1;
    end
  end

  // Delayed copy of stage two for edge finding
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_d <= '0;
    end else begin
      link_d <= link_s2;
    end
  end

  logic clk_rise;
  logic latch_rise;

  // Edges of the slow link clock and latch line
  assign clk_rise   = link_s2.clk & ~link_d.clk;
  assign latch_rise = link_s2.latch & ~link_d.latch;

  // ----------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------
  ipd_word_t shift_reg;

  // MSB first, one bit per link clock rising edge
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_reg <= '0;
    end else if (clk_rise) begin
      shift_reg <= {shift_reg[`IPD_WORD_W-2:0], link_s2.data};
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic test_hit;
  logic ref_hit;
  logic fb_hit;

  // Test code checked first, then reference, then feedback
  assign test_hit = latch_rise &
    (shift_reg[`IPD_TEST_CODE_W-1:0] == `IPD_TEST_CODE);
  assign ref_hit  = latch_rise & ~test_hit &
    (shift_reg[`IPD_REF_CODE_W-1:0] == `IPD_REF_CODE);
  assign fb_hit   = latch_rise & ~test_hit & ~ref_hit &
    (shift_reg[`IPD_FB_CODE_W-1:0] == `IPD_FB_CODE);

  logic fb_fix_ok;
  logic ref_fix_ok;

  // Fixed upper patterns, reported but not required
  assign fb_fix_ok  = shift_reg[`IPD_WORD_W-1:`IPD_FB_FIX_LSB]
                      == `IPD_FB_FIX;
  assign ref_fix_ok = shift_reg[`IPD_WORD_W-1:`IPD_REF_FIX_LSB]
                      == `IPD_REF_FIX;

  // ----------------------------------------------------------------
  // Programmed values
  // ----------------------------------------------------------------
  logic [3:0] prog_swallow;
  logic [8:0] prog_main;
  logic [8:0] prog_ref;
  logic       test_written;

  // Feedback-counter fields
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prog_swallow <= `IPD_DEF_SWALLOW;
      prog_main    <= `IPD_DEF_MAIN;
    end else if (fb_hit) begin
      prog_swallow <=
        shift_reg[`IPD_SWALLOW_MSB:`IPD_SWALLOW_LSB];
      prog_main    <= shift_reg[`IPD_MAIN_MSB:`IPD_MAIN_LSB];
    end
  end

  // Reference-divider field
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prog_ref <= `IPD_DEF_REF;
    end else if (ref_hit) begin
      prog_ref <= shift_reg[`IPD_REF_MSB:`IPD_REF_LSB];
    end
  end

  // Test word seen since reset
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      test_written <= 1'b0;
    end else if (test_hit) begin
      test_written <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Selection and outputs
  // ----------------------------------------------------------------
  ipd_div_cfg_t next_cfg;
  ipd_ratio_t   next_ratio;

  // Defaults unless default-select is low
  always_comb begin
    next_cfg.swallow = def_s2 ? DEF_SWALLOW : prog_swallow;
    next_cfg.main    = def_s2 ? DEF_MAIN    : prog_main;
    next_cfg.ref_div = def_s2 ? DEF_REF     : prog_ref;
    next_ratio = {next_cfg.main, 4'h0} +
                 {9'h000, next_cfg.swallow};
  end

  // Registered divider settings
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cfg_o  <= '0;
      fb_ratio_o <= '0;
    end else begin
      div_cfg_o  <= next_cfg;
      fb_ratio_o <= next_ratio;
    end
  end

  // Test mode and word status flags
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      test_active_o <= 1'b0;
      word_taken_o  <= 1'b0;
      fixed_bad_o   <= 1'b0;
    end else begin
      test_active_o <= test_written & ~def_s2;
      word_taken_o  <= fb_hit | ref_hit | test_hit;
      fixed_bad_o   <= (fb_hit & ~fb_fix_ok) | (ref_hit & ~ref_fix_ok);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_shift_in: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    clk_rise |=> shift_reg[0] == $past(link_s2.data))
    else $error("shift register missed a data bit");
  chk_fb_load: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    fb_hit |=> prog_swallow == $past(shift_reg[16:13])
           && prog_main == $past(shift_reg[12:4]))
    else $error("feedback word fields not loaded");
  chk_ref_load: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    ref_hit |=> prog_ref == $past(shift_reg[13:5]) && $stable(prog_main))
    else $error("reference word misrouted");
  chk_test_load: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    test_hit |=> test_written && $stable(prog_ref) && $stable(prog_main))
    else $error("test word misrouted");
  chk_fb_select: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !def_s2 ##1 1 |-> div_cfg_o.main == $past(prog_main)
                   && div_cfg_o.swallow == $past(prog_swallow))
    else $error("programmed feedback counts not applied");
  chk_fb_default: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    def_s2 |=> div_cfg_o.main == DEF_MAIN
            && div_cfg_o.swallow == DEF_SWALLOW)
    else $error("default feedback counts not kept");
  chk_ref_select: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    1 |=> div_cfg_o.ref_div == ($past(def_s2) ? DEF_REF : $past(prog_ref)))
    else $error("reference divide selection wrong");
  chk_fb_ratio: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    ##1 fb_ratio_o == 13'(16 * div_cfg_o.main) + 13'(div_cfg_o.swallow))
    else $error("feedback ratio wrong");
  chk_test_gate: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    1 |=> test_active_o == ($past(test_written) && !$past(def_s2)))
    else $error("test mode gating wrong");

endmodule

// ---- hw/ipd_defines.svh ----
/*
  Constants for the IF divider configuration words: address codes,
  field positions, fixed patterns and built-in default divider values.
  Assumes nothing; included by the package and the design module.
*/
`ifndef IPD_DEFINES_SVH
`define IPD_DEFINES_SVH

// ------------------------------------------------------------------
// Word format
// ------------------------------------------------------------------
`define IPD_WORD_W        24

// ------------------------------------------------------------------
// Address codes in the low bits of each word
// ------------------------------------------------------------------
`define IPD_FB_CODE       4'h7
`define IPD_FB_CODE_W     4
`define IPD_REF_CODE      5'h0F
`define IPD_REF_CODE_W    5
`define IPD_TEST_CODE     6'h1F
`define IPD_TEST_CODE_W   6

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define IPD_SWALLOW_MSB   16
`define IPD_SWALLOW_LSB   13
`define IPD_MAIN_MSB      12
`define IPD_MAIN_LSB      4
`define IPD_REF_MSB       13
`define IPD_REF_LSB       5
`define IPD_FB_FIX_LSB    17
`define IPD_FB_FIX        7'h08
`define IPD_REF_FIX_LSB   14
`define IPD_REF_FIX       10'h0C2

// ------------------------------------------------------------------
// Built-in defaults and ratio scaling
// ------------------------------------------------------------------
`define IPD_DEF_SWALLOW   4'h0
`define IPD_DEF_MAIN      9'h010
`define IPD_DEF_REF       9'h002
`define IPD_MAIN_SHIFT    4

`endif

// ---- hw/ipd_pkg.sv ----
/*
  Types for the IF divider configuration words.
  Assumes ipd_defines.svh is on the include path.
*/
`include "ipd_defines.svh"

package ipd_pkg;

  // Three-wire serial link pins, as seen at the device
  typedef struct packed {
    logic clk;
    logic data;
    logic latch;
  } ipd_serial_t;

  // Divider settings in force
  typedef struct packed {
    logic [3:0] swallow;
    logic [8:0] main;
    logic [8:0] ref_div;
  } ipd_div_cfg_t;

  typedef logic [`IPD_WORD_W-1:0] ipd_word_t;
  typedef logic [12:0]            ipd_ratio_t;

endpackage

// ---- test/ipd_host_model.sv ----
/*
  Host model: shifts 24-bit configuration words onto the serial link.
  Assumes ref_clk_i at 100 ns; link clock made at 800 ns period.
*/
`timescale 1ns/1ps

module ipd_host_model (
  input  wire logic           ref_clk_i,
  output ipd_pkg::ipd_serial_t link_o
);
  import ipd_pkg::*;

  // Link clock stands low between frames
  initial link_o = '0;

  // One word MSB first, 8-cycle link clock, then a short latch pulse;
  // returns early enough for the caller to see the taken pulse
  task automatic send(input ipd_word_t w);
    @(posedge ref_clk_i);
    for (int i = 23; i >= 0; i--) begin
      link_o.data <= w[i];
      link_o.clk  <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      link_o.clk <= 1'b1; // Data held across the rise
      repeat (4) @(posedge ref_clk_i);
    end
    link_o.clk <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    link_o.latch <= 1'b1;  // Latch after the 24th clock
    link_o.data  <= ~w[0]; // Released data shows the inverse
    repeat (2) @(posedge ref_clk_i);
    link_o.latch <= 1'b0;
  endtask
endmodule

// ---- test/ipd_config_words_bench.sv ----
/*
  Self-checking bench for the IF divider configuration words.
  Assumes the host model drives the link and the bench the default select.
*/
`timescale 1ns/1ps
`include "ipd_defines.svh"

module ipd_config_words_bench;
  import ipd_pkg::*;

  logic         ref_clk_i;
  logic         rst_i;
  logic         dflt;
  ipd_serial_t  link;
  ipd_div_cfg_t cfg;
  ipd_ratio_t   ratio;
  logic         test_act;
  logic         taken;
  logic         bad;
  ipd_word_t    w;
  int           mismatches;
  int           samples_checked;
  int           p_sw;
  int           p_main;
  int           p_ref;
  bit           seen_test;

  ipd_host_model host (.ref_clk_i(ref_clk_i), .link_o(link));

  ipd_config_words dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .link_i(link),
    .use_default_dividers_i(dflt), .div_cfg_o(cfg), .fb_ratio_o(ratio),
    .test_active_o(test_act), .word_taken_o(taken), .fixed_bad_o(bad)
  );

  // ----------------------------------------------------------------
  // Clock and checking tasks
  // ----------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (e !== g) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Model of the values in force
  task automatic check_cfg();
    int es, em, er;
    // Sample settled outputs, away from the launching edge
    @(negedge ref_clk_i);
    es = dflt ? `IPD_DEF_SWALLOW : p_sw;
    em = dflt ? `IPD_DEF_MAIN : p_main;
    er = dflt ? `IPD_DEF_REF : p_ref;
    chk("swallow", es, cfg.swallow);
    chk("main", em, cfg.main);
    chk("ref_div", er, cfg.ref_div);
    chk("ratio", 16 * em + es, ratio);
    chk("test_active", !dflt && seen_test, test_act);
  endtask

  // Send a word, count pulses over a bounded window
  task automatic xfer(input ipd_word_t wd, input int et, input int eb);
    int hits, bads;
    hits = 0;
    bads = 0;
    host.send(wd);
    repeat (16) begin
      @(negedge ref_clk_i);
      if (taken === 1'b1) hits++;
      if (bad === 1'b1) bads++;
    end
    chk("word_taken", et, hits);
    chk("fixed_bad", eb, bads);
    check_cfg();
  endtask

  task automatic set_dflt(input logic v);
    @(posedge ref_clk_i);
    dflt <= v;
    repeat (6) @(posedge ref_clk_i);
    check_cfg();
  endtask

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    dflt = 1'b1;
    mismatches = 0;
    samples_checked = 0;
    p_sw = `IPD_DEF_SWALLOW;
    p_main = `IPD_DEF_MAIN;
    p_ref = `IPD_DEF_REF;
    seen_test = 0;
    void'($urandom(32'hece0a537));
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    check_cfg();
    set_dflt(1'b0);
    // Feedback and reference words, boundaries first
    for (int k = 0; k < 4; k++) begin
      p_main = (k == 0) ? 511 : 1 + $urandom % 511;
      // Swallow kept below main and within 0..15
      p_sw = (k == 0) ? 15 : $urandom % ((p_main < 16) ? p_main : 16);
      xfer({7'h08, 4'(p_sw), 9'(p_main), 4'h7}, 1, 0);
      p_ref = (k == 0) ? 2 : (k == 1) ? 511 : 2 + $urandom % 510;
      xfer({10'h0C2, 9'(p_ref), 5'h0F}, 1, 0);
    end
    // Written while defaults selected, shown once released
    set_dflt(1'b1);
    p_main = 200;
    p_sw = 9;
    xfer({7'h08, 4'(p_sw), 9'(p_main), 4'h7}, 1, 0);
    p_ref = 77;
    xfer({10'h0C2, 9'(p_ref), 5'h0F}, 1, 0);
    set_dflt(1'b0);
    // Wrong top pattern still taken, flagged
    p_main = 33;
    p_sw = 4;
    xfer({7'h7F, 4'(p_sw), 9'(p_main), 4'h7}, 1, 1);
    xfer({10'h3FF, 9'(p_ref), 5'h0F}, 1, 1);
    // Unknown low code ignored
    xfer(24'h12_3456, 0, 0);
    // Test word only at the end, under both default-select levels
    set_dflt(1'b1);
    seen_test = 1;
    xfer({18'h0_0000, 6'h1F}, 1, 0);
    set_dflt(1'b0);
    print_verdict();
  end
endmodule
